// ### verilog/bce_defs.svh
// Offsets, field positions, reset values and condition codes of the
// branch condition evaluator.
// Assumes inclusion by bare name from the package and design files.
`ifndef BCE_DEFS_SVH
`define BCE_DEFS_SVH

// ----------------------------------------------------------------
// Register byte addresses
// ----------------------------------------------------------------
`define BCE_OFS_EVAL      8'h00
`define BCE_OFS_ACT       8'h04
`define BCE_OFS_RES       8'h08
`define BCE_OFS_APPLY     8'h0C
`define BCE_OFS_FLAGS     8'hFC

// ----------------------------------------------------------------
// Flag positions inside condition_flags
// ----------------------------------------------------------------
`define BCE_FLG_C         7
`define BCE_FLG_Z         6
`define BCE_FLG_S         5
`define BCE_FLG_V         4
`define BCE_FLG_D         3
`define BCE_FLG_H         2
`define BCE_NFLAGS        6
`define BCE_FLAGS_RST     8'h00

// ----------------------------------------------------------------
// Evaluation register fields
// ----------------------------------------------------------------
`define BCE_EVAL_TRUE_BIT 8
`define BCE_EVAL_RST      4'h0

// ----------------------------------------------------------------
// Condition field codes
// ----------------------------------------------------------------
`define BCE_CC_NEVER      4'h0
`define BCE_CC_SBELOW     4'h1
`define BCE_CC_SATMOST    4'h2
`define BCE_CC_UATMOST    4'h3
`define BCE_CC_WRAPSET    4'h4
`define BCE_CC_SIGNNEG    4'h5
`define BCE_CC_MATCH      4'h6
`define BCE_CC_UBELOW     4'h7
`define BCE_CC_ALWAYS     4'h8
`define BCE_CC_SATLEAST   4'h9
`define BCE_CC_SABOVE     4'hA
`define BCE_CC_UABOVE     4'hB
`define BCE_CC_WRAPCLR    4'hC
`define BCE_CC_SIGNPOS    4'hD
`define BCE_CC_DIFFER     4'hE
`define BCE_CC_UATLEAST   4'hF

`endif

// ### verilog/bce_pkg.sv
// Types shared by the branch condition evaluator files.
// Assumes bce_defs.svh is on the include path.
package bce_pkg;
    `include "bce_defs.svh"

    // Treatment of one flag by one instruction
    typedef enum logic [2:0]
    {
        BCE_ACT_KEEP,
        BCE_ACT_CLEAR,
        BCE_ACT_SET,
        BCE_ACT_RESULT,
        BCE_ACT_UNDEF
    } bce_act_type;

    typedef bce_act_type bce_act_vec_type [`BCE_NFLAGS];
endpackage

// ### verilog/bce_flag_if.sv
// Carrier between the top and the flag register unit.
// Assumes both ends run on the same clock.
`timescale 1ns/1ps
`include "bce_defs.svh"
interface bce_flag_if;
    import bce_pkg::*;
    logic                      wr_en;
    logic [7:0]                wr_data;
    logic                      upd_en;
    bce_act_vec_type           upd_act;
    logic [`BCE_NFLAGS-1:0]    upd_res;
    logic [7:0]                flags;

    modport top
    (
        output wr_en,
        output wr_data,
        output upd_en,
        output upd_act,
        output upd_res,
        input  flags
    );
    modport unit
    (
        input  wr_en,
        input  wr_data,
        input  upd_en,
        input  upd_act,
        input  upd_res,
        output flags
    );
endinterface

// ### verilog/bce_flag_unit.sv
// Flag control register with per-flag update treatment.
// Assumes the top resolves update priority before driving the carrier.
`timescale 1ns/1ps
`include "bce_defs.svh"
module bce_flag_unit
    import bce_pkg::*;
(
    // Clock and reset
    input  wire logic  pclk,
    input  wire logic  presetn,
    // Flag carrier
    bce_flag_if.unit   fl
);
    localparam int FPOS [`BCE_NFLAGS] = '{`BCE_FLG_C, `BCE_FLG_Z,
        `BCE_FLG_S, `BCE_FLG_V, `BCE_FLG_D, `BCE_FLG_H};

    logic [7:0] flags_r;
    logic [7:0] flags_nxt;

    // ----------------------------------------------------------------
    // Next flag value
    // ----------------------------------------------------------------
    always_comb
    begin
        flags_nxt = flags_r;
        if (fl.upd_en)
        begin
            for (int i = 0; i < `BCE_NFLAGS; i++)
            begin
                unique case (fl.upd_act[i])                       // RL8
                    BCE_ACT_KEEP:   flags_nxt[FPOS[i]] = flags_r[FPOS[i]];
                    BCE_ACT_CLEAR:  flags_nxt[FPOS[i]] = 1'b0;
                    BCE_ACT_SET:    flags_nxt[FPOS[i]] = 1'b1;
                    BCE_ACT_RESULT: flags_nxt[FPOS[i]] = fl.upd_res[i];
                    // Undefined flags simply hold their old value
                    BCE_ACT_UNDEF:  flags_nxt[FPOS[i]] = flags_r[FPOS[i]];
                    default:        flags_nxt[FPOS[i]] = flags_r[FPOS[i]];
                endcase
            end
        end
        else if (fl.wr_en)
        begin
            flags_nxt = fl.wr_data;                               // RL1
        end
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            flags_r <= `BCE_FLAGS_RST;
        end
        else
        begin
            flags_r <= flags_nxt;
        end
    end

    assign fl.flags = flags_r;
endmodule

// ### verilog/bce_top.sv
// Branch condition evaluator with flag control register, APB slave.
// Assumes a synchronous core sequencer and an APB master on pclk.
`timescale 1ns/1ps
`include "bce_defs.svh"

// Functional notes
// [RL1] Six flags C Z S V D H live in condition_flags; evaluator reads them. The evaluator here uses only C Z S V.
// [RL2] Field 0111 true when carry set; 1111 true when carry clear.
// [RL3] Field 0110 true when zero set; 1110 true when zero clear.
// [RL4] 1101 sign clear, 0101 sign set, 0100 wrap set, 1100 wrap clear.
// [RL5] 1001 true when S xor V is 0; 0001 when it is 1.
// [RL6] 1010 true when Z or (S xor V) is 0; 0010 when 1.
// [RL7] 1011 true when C and Z both clear; 0011 when C or Z set.
// [RL8] Each flag is cleared, set, from result, kept or undefined per op.
// [RL9] 1000 always true, 0000 never; output combinational from field, flags.
module bce_top
    import bce_pkg::*;
(
    // Clock and reset
    input  wire logic                   pclk,
    input  wire logic                   presetn,
    // APB slave
    input  wire logic                   psel,
    input  wire logic                   penable,
    input  wire logic                   pwrite,
    input  wire logic [7:0]             paddr,
    input  wire logic [31:0]            pwdata,
    output logic      [31:0]            prdata,
    output logic                        pready,
    output logic                        pslverr,
    // Sequencer condition query
    input  wire logic [3:0]             cond_field,
    output logic                        cond_true,
    // Sequencer flag update
    input  wire logic                   upd_valid,
    input  wire logic [3*`BCE_NFLAGS-1:0] upd_act,
    input  wire logic [`BCE_NFLAGS-1:0] upd_res,
    // Flag view
    output logic      [7:0]             flags_out
);
    bce_flag_if fl ();

    logic                       wait_r;
    logic                       wait_nxt;
    logic [31:0]                rdata_r;
    logic [31:0]                rdata_nxt;
    logic                       err_r;
    logic                       err_nxt;
    logic [3:0]                 eval_field_r;
    logic [3:0]                 eval_field_nxt;
    logic [3*`BCE_NFLAGS-1:0]   act_r;
    logic [3*`BCE_NFLAGS-1:0]   act_nxt;
    logic [`BCE_NFLAGS-1:0]     res_r;
    logic [`BCE_NFLAGS-1:0]     res_nxt;
    logic                       access;
    logic                       commit;
    logic                       wr_commit;
    logic                       mapped;
    logic                       sw_apply;
    logic                       eval_true;
    logic [7:0]                 flags;

    // ----------------------------------------------------------------
    // Condition evaluation
    // ----------------------------------------------------------------
    function automatic logic bce_eval(input logic [3:0] cc,
                                      input logic [7:0] f);
        logic c;
        logic z;
        logic s;
        logic v;
        logic r;
        c = f[`BCE_FLG_C];
        z = f[`BCE_FLG_Z];
        s = f[`BCE_FLG_S];
        v = f[`BCE_FLG_V];
        r = 1'b0;
        unique case (cc)
            `BCE_CC_NEVER:    r = 1'b0;                          // RL9
            `BCE_CC_ALWAYS:   r = 1'b1;                          // RL9
            `BCE_CC_UBELOW:   r = c;                             // RL2
            `BCE_CC_UATLEAST: r = !c;                            // RL2
            `BCE_CC_MATCH:    r = z;                             // RL3
            `BCE_CC_DIFFER:   r = !z;                            // RL3
            `BCE_CC_SIGNPOS:  r = !s;                            // RL4
            `BCE_CC_SIGNNEG:  r = s;                             // RL4
            `BCE_CC_WRAPSET:  r = v;                             // RL4
            `BCE_CC_WRAPCLR:  r = !v;                            // RL4
            `BCE_CC_SATLEAST: r = !(s ^ v);                      // RL5
            `BCE_CC_SBELOW:   r = s ^ v;                         // RL5
            `BCE_CC_SABOVE:   r = !(z | (s ^ v));                // RL6
            `BCE_CC_SATMOST:  r = z | (s ^ v);                   // RL6
            `BCE_CC_UABOVE:   r = !c && !z;                      // RL7
            `BCE_CC_UATMOST:  r = c | z;                         // RL7
        endcase
        return r;
    endfunction

    assign flags     = fl.flags;
    assign cond_true = bce_eval(cond_field, flags);              // RL1
    assign eval_true = bce_eval(eval_field_r, flags);
    assign flags_out = flags;

    // ----------------------------------------------------------------
    // APB decode
    // ----------------------------------------------------------------
    // One wait state lets read data come from a flop.
    assign access    = psel && penable;
    assign commit    = access && wait_r;
    assign wr_commit = commit && pwrite && !err_r;
    assign pready    = wait_r;
    assign pslverr   = wait_r && err_r;
    assign prdata    = rdata_r;
    assign sw_apply  = wr_commit && (paddr == `BCE_OFS_APPLY);

    always_comb
    begin
        unique case (paddr)
            `BCE_OFS_EVAL,
            `BCE_OFS_ACT,
            `BCE_OFS_RES,
            `BCE_OFS_APPLY,
            `BCE_OFS_FLAGS: mapped = 1'b1;
            default:        mapped = 1'b0;
        endcase
    end

    // ----------------------------------------------------------------
    // APB answer state
    // ----------------------------------------------------------------
    always_comb
    begin
        wait_nxt  = 1'b0;
        rdata_nxt = rdata_r;
        err_nxt   = err_r;
        if (access && !wait_r)
        begin
            wait_nxt = 1'b1;
            err_nxt  = !mapped;
            rdata_nxt = 32'h0000_0000;
            if (!pwrite)
            begin
                unique case (paddr)
                    `BCE_OFS_EVAL:
                    begin
                        rdata_nxt[3:0] = eval_field_r;
                        rdata_nxt[`BCE_EVAL_TRUE_BIT] = eval_true;
                    end
                    `BCE_OFS_ACT:
                    begin
                        rdata_nxt[3*`BCE_NFLAGS-1:0] = act_r;
                    end
                    `BCE_OFS_RES:
                    begin
                        rdata_nxt[`BCE_NFLAGS-1:0] = res_r;
                    end
                    `BCE_OFS_FLAGS:
                    begin
                        rdata_nxt[7:0] = flags;                   // RL1
                    end
                    default:
                    begin
                        rdata_nxt = 32'h0000_0000;
                    end
                endcase
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            wait_r  <= 1'b0;
            rdata_r <= 32'h0000_0000;
            err_r   <= 1'b0;
        end
        else
        begin
            wait_r  <= wait_nxt;
            rdata_r <= rdata_nxt;
            err_r   <= err_nxt;
        end
    end

    // ----------------------------------------------------------------
    // Software control registers
    // ----------------------------------------------------------------
    always_comb
    begin
        eval_field_nxt = eval_field_r;
        act_nxt        = act_r;
        res_nxt        = res_r;
        if (wr_commit)
        begin
            unique case (paddr)
                `BCE_OFS_EVAL:
                begin
                    eval_field_nxt = pwdata[3:0];
                end
                `BCE_OFS_ACT:
                begin
                    act_nxt = pwdata[3*`BCE_NFLAGS-1:0];
                end
                `BCE_OFS_RES:
                begin
                    res_nxt = pwdata[`BCE_NFLAGS-1:0];
                end
                default:
                begin
                    eval_field_nxt = eval_field_r;
                end
            endcase
        end
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            eval_field_r <= `BCE_EVAL_RST;
            act_r        <= '0;
            res_r        <= '0;
        end
        else
        begin
            eval_field_r <= eval_field_nxt;
            act_r        <= act_nxt;
            res_r        <= res_nxt;
        end
    end

    // ----------------------------------------------------------------
    // Flag update routing
    // ----------------------------------------------------------------
    // A sequencer update beats a software apply in the same cycle.
    always_comb
    begin
        fl.wr_en   = wr_commit && (paddr == `BCE_OFS_FLAGS);
        fl.wr_data = pwdata[7:0];
        fl.upd_en  = upd_valid || sw_apply;                       // RL8
        fl.upd_res = upd_valid ? upd_res : res_r;
        for (int i = 0; i < `BCE_NFLAGS; i++)
        begin
            fl.upd_act[i] = bce_act_type'(upd_valid ?
                upd_act[3*i +: 3] : act_r[3*i +: 3]);
        end
    end

    bce_flag_unit u_flags
    (
        .pclk    (pclk),
        .presetn (presetn),
        .fl      (fl.unit)
    );
endmodule

// ### dv/bce_top_asserts.sv
// Checker of the condition evaluator and flag register.
// Assumes it is bound to bce_top and sees only its ports.
`timescale 1ns/1ps
module bce_top_asserts
(
    // Clock and reset
    input logic        pclk,
    input logic        presetn,
    // APB slave
    input logic        psel,
    input logic        penable,
    input logic        pwrite,
    input logic [7:0]  paddr,
    input logic [31:0] pwdata,
    input logic [31:0] prdata,
    input logic        pready,
    input logic        pslverr,
    // Sequencer side
    input logic [3:0]  cond_field,
    input logic        cond_true,
    input logic        upd_valid,
    input logic [17:0] upd_act,
    input logic [5:0]  upd_res,
    input logic [7:0]  flags_out
);
    logic       c;
    logic       z;
    logic       s;
    logic       v;
    logic [2:0] k;
    logic       n;
    assign c = flags_out[7];
    assign z = flags_out[6];
    assign s = flags_out[5];
    assign v = flags_out[4];
    assign k = cond_field[2:0];
    assign n = cond_field[3];

    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    // ------------------------------------------------------------
    // Condition codes
    // ------------------------------------------------------------
    a_carry_codes: assert property (k == 3'h7 |-> cond_true == (c ^ n))
        else $error("carry condition wrong");
    a_zero_codes: assert property (k == 3'h6 |-> cond_true == (z ^ n))
        else $error("zero condition wrong");
    a_sign_wrap: assert property (k[2:1] == 2'h2 |->
        cond_true == ((k[0] ? s : v) ^ n)) else $error("sign or wrap wrong");
    a_signed_lt: assert property (k == 3'h1 |-> cond_true == (s ^ v ^ n))
        else $error("signed below wrong");
    a_signed_le: assert property (k == 3'h2 |->
        cond_true == ((z | (s ^ v)) ^ n)) else $error("signed at most wrong");
    a_unsigned_le: assert property (k == 3'h3 |->
        cond_true == ((c | z) ^ n)) else $error("unsigned wrong");
    a_fixed_codes: assert property (k == 3'h0 |-> cond_true == n)
        else $error("fixed condition wrong");

    // ------------------------------------------------------------
    // Register access and flag treatment
    // ------------------------------------------------------------
    sequence apb_setup;
        psel && !penable;
    endsequence
    sequence apb_answer;
        penable && !pready ##1 penable && pready;
    endsequence
    a_apb_wait: assert property (apb_setup |=> apb_answer)
        else $error("access phase length wrong");
    a_flag_force: assert property (upd_valid && (upd_act[2:0] == 3'h1 ||
        upd_act[2:0] == 3'h2) |=> c == $past(upd_act[1]))
        else $error("forced flag wrong");
    a_flag_result: assert property (upd_valid && upd_act[2:0] == 3'h3
        |=> c == $past(upd_res[0])) else $error("result flag wrong");
    a_flag_keep: assert property (upd_valid && upd_act[2:0] == 3'h0
        |=> $stable(c)) else $error("kept flag changed");
endmodule

bind bce_top bce_top_asserts i_chk (.pclk, .presetn, .psel, .penable,
    .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr, .cond_field,
    .cond_true, .upd_valid, .upd_act, .upd_res, .flags_out);

// ### dv/bce_seq_model.sv
// Sequencer model: condition queries and flag updates.
// Assumes the bench calls its tasks from one process.
`timescale 1ns/1ps
module bce_seq_model
(
    // Clock
    input  logic        pclk,
    // Query and update
    output logic [3:0]  cond_field,
    output logic        upd_valid,
    output logic [17:0] upd_act,
    output logic [5:0]  upd_res
);
    initial
    begin
        cond_field = 4'h0;
        upd_valid  = 1'b0;
        upd_act    = 18'h00000;
        upd_res    = 6'h00;
    end
    task automatic query(input logic [3:0] f);
        @(posedge pclk);
        cond_field <= f;
    endtask
    task automatic update(input logic [17:0] a, input logic [5:0] r);
        @(posedge pclk);
        upd_valid <= 1'b1;
        upd_act   <= a;
        upd_res   <= r;
    endtask
    // Ignored lines do not keep their last value
    task automatic idle();
        @(posedge pclk);
        upd_valid <= 1'b0;
        upd_act   <= ~upd_act;
        upd_res   <= ~upd_res;
    endtask
endmodule

// ### dv/tb_top.sv
// Self-checking bench of the condition evaluator.
// Assumes bce_top, bce_seq_model and the bound checker.
`timescale 1ns/1ps
`include "bce_defs.svh"
module tb_top;
    logic        pclk;
    logic        presetn;
    logic        psel;
    logic        penable;
    logic        pwrite;
    logic [7:0]  paddr;
    logic [31:0] pwdata;
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
    logic [3:0]  cond_field;
    logic        cond_true;
    logic        upd_valid;
    logic [17:0] upd_act;
    logic [5:0]  upd_res;
    logic [7:0]  flags_out;
    logic [31:0] rd;
    logic        er;
    int          err_total = 0;
    int          total_checks = 0;
    typedef struct {logic [7:0] fl; logic [15:0] mask;} bce_row_type;
    // Bit k of mask: condition code k is true for these flags
    bce_row_type rows [8] = '{'{8'h00, 16'hFF00}, '{8'h80, 16'h7788},
        '{8'h40, 16'hB34C}, '{8'h20, 16'hD926}, '{8'h10, 16'hE916},
        '{8'h30, 16'hCF30}, '{8'hE0, 16'h11EE}, '{8'h0F, 16'hFF00}};

    bce_top i_dut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr,
        .pwdata, .prdata, .pready, .pslverr, .cond_field, .cond_true,
        .upd_valid, .upd_act, .upd_res, .flags_out);
    bce_seq_model i_seq (.pclk, .cond_field, .upd_valid, .upd_act,
        .upd_res);

    initial
    begin
        pclk = 1'b0;
        forever #4 pclk = ~pclk;
    end

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        total_checks++;
        if (got !== exp)
        begin
            err_total++;
            $display("[FAIL] t=%0t got %h exp %h", $time, got, exp);
        end
    endtask

    task automatic apb(input logic w, input logic [7:0] a,
        input logic [31:0] d);
        int n;
        n = 0;
        @(posedge pclk);
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= w;
        paddr   <= a;
        pwdata  <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do
        begin
            @(posedge pclk);
            n++;
        end
        while (pready !== 1'b1 && n < 50);
        if (pready !== 1'b1)
            err_total++;
        rd = prdata;
        er = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic stop_test();
        $display("checks %0d mismatches %0d", total_checks, err_total);
        if (err_total == 0 && total_checks > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask

    initial
    begin
        #100000;
        err_total++;
        stop_test();
    end

    initial
    begin
        presetn = 1'b0;
        psel    = 1'b0;
        penable = 1'b0;
        pwrite  = 1'b0;
        paddr   = 8'h00;
        pwdata  = 32'h00000000;
        repeat (20) @(posedge pclk);
        presetn <= 1'b1;
        foreach (rows[i])
        begin
            apb(1'b1, `BCE_OFS_FLAGS, 32'(rows[i].fl));
            apb(1'b0, `BCE_OFS_FLAGS, 32'h00000000);
            chk(rd, 32'(rows[i].fl));
            for (int k = 0; k < 16; k++)
            begin
                i_seq.query(4'(k));
                @(negedge pclk);
                chk(32'(cond_true), 32'(rows[i].mask[k]));
            end
        end
        $display("test condition rows done");
        apb(1'b1, `BCE_OFS_FLAGS, 32'h00000080);
        apb(1'b1, `BCE_OFS_EVAL, 32'h00000007);
        apb(1'b0, `BCE_OFS_EVAL, 32'h00000000);
        chk(rd, 32'h00000107);
        apb(1'b0, 8'h40, 32'h00000000);
        chk({rd[30:0], er}, 32'h00000001);
        $display("test register access done");
        apb(1'b1, `BCE_OFS_FLAGS, 32'h000000FC);
        i_seq.update({3'h7, 3'h4, 3'h0, 3'h3, 3'h2, 3'h1}, 6'h00);
        i_seq.idle();
        @(negedge pclk);
        chk(32'(flags_out), 32'h0000005C);
        i_seq.update(18'h00003, 6'h01);
        i_seq.update(18'h00000, 6'h3E);
        i_seq.idle();
        @(negedge pclk);
        chk(32'(flags_out), 32'h000000DC);
        $display("test flag update done");
        // Software path: C result, Z clear, S result, V keep, D clear, H set
        apb(1'b1, `BCE_OFS_ACT, 32'h000110CB);
        apb(1'b1, `BCE_OFS_RES, 32'h0000000E);
        apb(1'b0, `BCE_OFS_ACT, 32'h00000000);
        chk(rd, 32'h000110CB);
        apb(1'b0, `BCE_OFS_RES, 32'h00000000);
        chk(rd, 32'h0000000E);
        apb(1'b1, `BCE_OFS_APPLY, 32'h00000001);
        apb(1'b0, `BCE_OFS_APPLY, 32'h00000000);
        chk({rd[23:0], flags_out}, 32'h00000034);
        // Sequencer update lands in the write's completing cycle and wins
        fork
            apb(1'b1, `BCE_OFS_FLAGS, 32'h000000FF);
            begin
                repeat (2) @(posedge pclk);
                i_seq.update(18'h00010, 6'h00);
                i_seq.idle();
            end
        join
        @(negedge pclk);
        chk(32'(flags_out), 32'h00000074);
        $display("test software apply done");
        @(posedge pclk);
        presetn <= 1'b0;
        @(negedge pclk);
        chk({cond_true, 23'h000000, flags_out}, 32'h80000000);
        repeat (20) @(posedge pclk);
        presetn <= 1'b1;
        apb(1'b0, `BCE_OFS_FLAGS, 32'h00000000);
        chk(rd, 32'h00000000);
        $display("test reset done");
        stop_test();
    end
endmodule
